// *** rtl/serial_port_mode_control.sv ***
// Serial port mode control: line driver, receiver and handshake control.
// Assumes a UART core beside it supplies tx/rx data and busy flags on clk_in.
//
// How it works
// R1 - Bus master mode: switches 1-4 off, 5 on, 8 off; with switch 2 four-wire auto.
// R2 - Two-wire auto mode: switches 1,2 on; 3,4,5,8 off.
// R3 - RS232 mode is the default for every other switch setting.
// R4 - RS232 hardware handshake: RTS follows ability to accept received data.
// R5 - Hardware handshake: transmit only while CTS is asserted.
// R6 - Hardware handshake: DTR follows presence of a TCP connection.
// R7 - Bus master: drivers and receivers always on, handshake lines both ways.
// R8 - Auto modes: driver on when sending begins, off after last bit sent.
// R9 - Four-wire auto: receiver always enabled.
// R10 - Two-wire auto: receiver off while driver is on.
// R11 - Configuring party selects no flow control in RS485 modes.
// R12 - Current loop: baud rates above 19200 are rejected.
// R13 - Current loop: half-duplex select low suppresses echo of own transmit data.
// R14 - Switches are sampled after reset and held until next reset.
`timescale 1ns/100ps
module serial_port_mode_control (
  input  wire logic        clk_in,
  input  wire logic        reset_in,
  input  wire logic [7:0]  switches_in,
  input  wire logic        current_loop_in,
  input  wire logic        hw_handshake_in,
  input  wire logic        rx_can_accept_in,
  input  wire logic        tcp_connected_in,
  input  wire logic        tx_pending_in,
  input  wire logic        tx_busy_in,
  input  wire logic        tx_data_in,
  input  wire logic        cts_in,
  input  wire logic        rx_data_in,
  input  wire logic        half_duplex_select_n_in,
  input  wire logic [15:0] baud_divisor_in,
  output logic             tx_line_out,
  output logic             tx_allowed_out,
  output logic             rts_out,
  output logic             dtr_out,
  output logic             driver_enable_out,
  output logic             receiver_enable_out,
  output logic             rx_data_out,
  output logic             baud_reject_out,
  output logic [2:0]       mode_out
);

  mode_cfg_if cfg_bus ();

  mode_decoder decoder (
    .clk_in      (clk_in),
    .reset_in    (reset_in),
    .switches_in (switches_in),
    .cfg         (cfg_bus.source)
  );

  // ----------------------------------------------------------------
  // Mode flags
  // ----------------------------------------------------------------
  logic is_rs232;
  logic is_master;
  logic is_auto4;
  logic is_auto2;
  logic is_auto;
  logic handshake;
  logic sending;

  assign is_rs232  = cfg_bus.mode == serial_mode_pkg::MODE_RS232;
  assign is_master = cfg_bus.mode == serial_mode_pkg::MODE_BUS_MASTER;
  assign is_auto4  = cfg_bus.mode == serial_mode_pkg::MODE_FOUR_WIRE_AUTO;
  assign is_auto2  = cfg_bus.mode == serial_mode_pkg::MODE_TWO_WIRE_AUTO;
  assign is_auto   = is_auto4 || is_auto2;
  // Handshake lines exist only in RS232 and bus master mode
  assign handshake = hw_handshake_in && (is_rs232 || is_master);
  // Bit still on the wire or a new word queued
  assign sending   = tx_pending_in || tx_busy_in;

  // ----------------------------------------------------------------
  // Next values
  // ----------------------------------------------------------------
  logic       next_tx_line;
  logic       next_tx_allowed;
  logic       next_rts;
  logic       next_dtr;
  logic       next_drv;
  logic       next_rcv;
  logic       next_rx;
  logic       next_reject;
  logic [2:0] next_mode_out;

  always_comb begin
    next_tx_allowed = handshake ? cts_in : 1'b1;              // R5
    next_tx_line    = next_tx_allowed ? tx_data_in : 1'b1;    // R5
    next_rts        = handshake ? rx_can_accept_in : 1'b1;    // R4
    next_dtr        = handshake ? tcp_connected_in : 1'b1;    // R6
    next_drv        = 1'b1;                                   // R7
    next_rcv        = 1'b1;                                   // R7 R9
    if (is_auto) begin
      next_drv = sending;                                     // R8
    end
    if (is_auto2) begin
      next_rcv = !sending;                                    // R10
    end
    // Line stays quiet until the switch bank has been sampled
    if (!cfg_bus.valid) begin                                 // R14
      next_drv = 1'b0;
      next_rcv = 1'b0;
    end
    next_rx = rx_data_in;
    if (current_loop_in && !half_duplex_select_n_in && sending) begin
      next_rx = 1'b1;                                         // R13
    end else if (!next_rcv) begin
      next_rx = 1'b1;
    end
    next_reject   = current_loop_in
                  && baud_divisor_in < serial_mode_pkg::MIN_LOOP_DIVISOR; // R12
    next_mode_out = 3'(cfg_bus.mode);
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      tx_line_out         <= 1'b1;
      tx_allowed_out      <= 1'b0;
      rts_out             <= 1'b0;
      dtr_out             <= 1'b0;
      driver_enable_out   <= 1'b0;
      receiver_enable_out <= 1'b0;
      rx_data_out         <= 1'b1;
      baud_reject_out     <= 1'b0;
      mode_out            <= 3'h0;
    end else begin
      tx_line_out         <= next_tx_line;
      tx_allowed_out      <= next_tx_allowed;
      rts_out             <= next_rts;
      dtr_out             <= next_dtr;
      driver_enable_out   <= next_drv;
      receiver_enable_out <= next_rcv;
      rx_data_out         <= next_rx;
      baud_reject_out     <= next_reject;
      mode_out            <= next_mode_out;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence send_start;
    cfg_bus.valid && is_auto && sending;
  endsequence

  sequence send_done;
    cfg_bus.valid && is_auto && !sending;
  endsequence

  sequence two_wire_send;
    cfg_bus.valid && is_auto2 && sending;
  endsequence

  sequence two_wire_idle;
    cfg_bus.valid && is_auto2 && !sending;
  endsequence

  sequence loop_receive;
    cfg_bus.valid && !is_auto2 && current_loop_in && half_duplex_select_n_in;
  endsequence

  AST_DRIVER_ON: assert property (@(posedge clk_in) disable iff (reset_in) // R8
    send_start |=> driver_enable_out) else $error("driver not enabled");
  AST_DRIVER_OFF: assert property (@(posedge clk_in) disable iff (reset_in) // R8
    send_done |=> !driver_enable_out) else $error("driver not released");
  AST_TWO_WIRE_RX: assert property (@(posedge clk_in) disable iff (reset_in) // R10
    is_auto2 && cfg_bus.valid |=> receiver_enable_out != driver_enable_out)
    else $error("two-wire receiver overlaps driver");
  AST_FOUR_WIRE_RX: assert property (@(posedge clk_in) disable iff (reset_in) // R9
    is_auto4 && cfg_bus.valid |=> receiver_enable_out) else $error("receiver off");
  AST_MASTER_ON: assert property (@(posedge clk_in) disable iff (reset_in) // R7
    is_master && cfg_bus.valid |=> driver_enable_out && receiver_enable_out)
    else $error("bus master line off");
  AST_CTS_HOLD: assert property (@(posedge clk_in) disable iff (reset_in) // R5
    handshake && !cts_in |=> !tx_allowed_out && tx_line_out)
    else $error("sent while CTS low");
  AST_RTS: assert property (@(posedge clk_in) disable iff (reset_in) // R4
    handshake |=> rts_out == $past(rx_can_accept_in)) else $error("RTS wrong");
  AST_DTR: assert property (@(posedge clk_in) disable iff (reset_in) // R6
    handshake |=> dtr_out == $past(tcp_connected_in)) else $error("DTR wrong");
  AST_ECHO: assert property (@(posedge clk_in) disable iff (reset_in) // R13
    current_loop_in && !half_duplex_select_n_in && sending |=> rx_data_out)
    else $error("echo not suppressed");
  AST_BAUD: assert property (@(posedge clk_in) disable iff (reset_in) // R12
    current_loop_in && baud_divisor_in < serial_mode_pkg::MIN_LOOP_DIVISOR |=> baud_reject_out)
    else $error("fast baud accepted");

  // ----------------------------------------------------------------
  // Start-up and pass-through checks
  // ----------------------------------------------------------------
  AST_SETUP_QUIET: assert property (@(posedge clk_in) disable iff (reset_in) // R14
    !cfg_bus.valid |=> !driver_enable_out && !receiver_enable_out)
    else $error("line enabled before mode known");
  AST_MODE_OUT: assert property (@(posedge clk_in) disable iff (reset_in) // R14
    cfg_bus.valid |=> mode_out == 3'($past(cfg_bus.mode)))
    else $error("reported mode differs from latched mode");
  AST_TX_FREE: assert property (@(posedge clk_in) disable iff (reset_in) // R5
    !handshake |=> tx_allowed_out && tx_line_out == $past(tx_data_in))
    else $error("transmit held without handshake");
  AST_TX_PASS: assert property (@(posedge clk_in) disable iff (reset_in) // R5
    handshake && cts_in |=> tx_allowed_out && tx_line_out == $past(tx_data_in))
    else $error("transmit blocked while CTS high");
  AST_LINES_IDLE: assert property (@(posedge clk_in) disable iff (reset_in) // R6
    !handshake |=> rts_out && dtr_out)
    else $error("handshake outputs low without handshake");
  AST_TWO_WIRE_TURN: assert property (@(posedge clk_in) disable iff (reset_in) // R10
    two_wire_send ##1 two_wire_idle |=> receiver_enable_out && !driver_enable_out)
    else $error("two-wire turnaround wrong");
  AST_TWO_WIRE_MASK: assert property (@(posedge clk_in) disable iff (reset_in) // R10
    two_wire_send |=> rx_data_out)
    else $error("receive data seen while driving");
  AST_FOUR_WIRE_PASS: assert property (@(posedge clk_in) disable iff (reset_in) // R9
    cfg_bus.valid && is_auto4 && !current_loop_in |=> rx_data_out == $past(rx_data_in))
    else $error("four-wire receive data lost");
  AST_ECHO_PASS: assert property (@(posedge clk_in) disable iff (reset_in) // R13
    loop_receive |=> rx_data_out == $past(rx_data_in))
    else $error("loop receive data lost in full duplex");
  AST_BAUD_OK: assert property (@(posedge clk_in) disable iff (reset_in) // R12
    current_loop_in && baud_divisor_in >= serial_mode_pkg::MIN_LOOP_DIVISOR
    |=> !baud_reject_out) else $error("legal loop baud rejected");
  AST_NO_LOOP_REJECT: assert property (@(posedge clk_in) disable iff (reset_in) // R12
    !current_loop_in |=> !baud_reject_out) else $error("baud rejected outside loop");

endmodule : serial_port_mode_control

// *** rtl/serial_mode_pkg.sv ***
// Constants and types for the serial port mode control block.
// Assumes a single 20 MHz clock domain.
package serial_mode_pkg;

  typedef enum logic [2:0] {
    MODE_RS232,
    MODE_BUS_MASTER,
    MODE_FOUR_WIRE_AUTO,
    MODE_TWO_WIRE_AUTO,
    MODE_UNSUPPORTED
  } port_mode_type;

  // Clock rate and baud limit of the current-loop variant
  localparam int unsigned CLOCK_HZ           = 20000000;
  localparam int unsigned LOOP_MAX_BAUD      = 19200;
  // Baud divisor is clock cycles per bit; smallest legal divisor
  localparam logic [15:0] MIN_LOOP_DIVISOR   =
    16'((CLOCK_HZ + LOOP_MAX_BAUD - 1) / LOOP_MAX_BAUD);
  // Reset value of the sampled switch bank (all off)
  localparam logic [7:0]  SWITCH_RESET       = 8'h00;
  // Bit positions of the switches in the bank
  localparam int unsigned SW_ONE_BIT         = 0;
  localparam int unsigned SW_TWO_BIT         = 1;
  localparam int unsigned SW_THREE_BIT       = 2;
  localparam int unsigned SW_FOUR_BIT        = 3;
  localparam int unsigned SW_FIVE_BIT        = 4;
  localparam int unsigned SW_EIGHT_BIT       = 7;

endpackage : serial_mode_pkg

// *** rtl/mode_cfg_if.sv ***
// Carries the latched mode from the decoder to the port control.
// Assumes both ends sit on clk_in.
`timescale 1ns/100ps
interface mode_cfg_if;
  serial_mode_pkg::port_mode_type mode;
  logic                           valid;
  modport source (output mode, output valid);
  modport sink   (input mode, input valid);
endinterface : mode_cfg_if

// *** rtl/mode_decoder.sv ***
// Samples the switch bank once after reset and decodes the port mode.
// Assumes the switches are static and synchronous to clk_in.
`timescale 1ns/100ps
module mode_decoder (
  input  wire logic       clk_in,
  input  wire logic       reset_in,
  input  wire logic [7:0] switches_in,
  mode_cfg_if.source      cfg
);

  serial_mode_pkg::port_mode_type mode;
  serial_mode_pkg::port_mode_type next_mode;
  logic                           valid;
  logic                           next_valid;
  logic                           s1;
  logic                           s2;
  logic                           rest_off;

  assign s1       = switches_in[serial_mode_pkg::SW_ONE_BIT];
  assign s2       = switches_in[serial_mode_pkg::SW_TWO_BIT];
  assign rest_off = !switches_in[serial_mode_pkg::SW_THREE_BIT]
                  && !switches_in[serial_mode_pkg::SW_FOUR_BIT]
                  && !switches_in[serial_mode_pkg::SW_EIGHT_BIT];

  always_comb begin
    next_mode  = mode;
    next_valid = 1'b1;
    if (!valid) begin                                         // R14
      if (switches_in[serial_mode_pkg::SW_EIGHT_BIT]) begin
        next_mode = serial_mode_pkg::MODE_RS232;              // R3
      end else if (rest_off && !s1
          && switches_in[serial_mode_pkg::SW_FIVE_BIT]) begin
        next_mode = s2 ? serial_mode_pkg::MODE_FOUR_WIRE_AUTO
                       : serial_mode_pkg::MODE_BUS_MASTER;     // R1
      end else if (rest_off && s1 && s2
          && !switches_in[serial_mode_pkg::SW_FIVE_BIT]) begin
        next_mode = serial_mode_pkg::MODE_TWO_WIRE_AUTO;       // R2
      end else begin
        next_mode = serial_mode_pkg::MODE_RS232;              // R3
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      mode  <= serial_mode_pkg::MODE_RS232;
      valid <= 1'b0;
    end else begin
      mode  <= next_mode;
      valid <= next_valid;
    end
  end

  assign cfg.mode  = mode;
  assign cfg.valid = valid;

  AST_MODE_HELD: assert property (@(posedge clk_in) disable iff (reset_in) // R14
    $past(valid) |-> $stable(mode)) else $error("mode changed after sampling");

endmodule : mode_decoder

// *** verif/serial_peer_model.sv ***
// Far-side serial device: drives CTS and the receive line of the port.
// Assumes the bench steers its readiness and the bits it sends on clk_in.
`timescale 1ns/100ps
module serial_peer_model (
  input  wire logic clk_in,
  input  wire logic ready_in,
  input  wire logic send_in,
  input  wire logic bit_in,
  input  wire logic rts_in,
  output logic      cts_out = 1'b0,
  output logic      rxd_out = 1'b1
);
  // ------------------------------------------------------------
  // Line drive
  // ------------------------------------------------------------
  always @(posedge clk_in) begin
    cts_out <= ready_in;
    // Sends only while the port can take data; the line idles at mark
    rxd_out <= (send_in && rts_in) ? bit_in : 1'b1;
  end
endmodule : serial_peer_model

// *** verif/tb_top.sv ***
// Self-checking bench for the serial port mode control block.
// Assumes one 20 MHz clock and a peer model on the serial side.
`timescale 1ns/100ps
module tb_top;
  logic        clk_in      = 1'b0;
  logic        reset_in    = 1'b1;
  logic [7:0]  switches_in = 8'h00;
  logic        loop_sel = 1'b0, hw_hs = 1'b0, can_acc = 1'b0, tcp = 1'b0;
  logic        pend = 1'b0, busy = 1'b0, txd = 1'b0, hd_n = 1'b1;
  logic        p_ready = 1'b0, p_send = 1'b0, p_bit = 1'b1;
  logic [15:0] div = 16'h0412;
  logic        cts, rxd, tx_line, tx_ok, rts, dtr, drv_en, rcv_en, rx_out, reject;
  logic [2:0]  mode;
  logic [7:0]  sw_tab [5]   = '{8'h10, 8'h12, 8'h03, 8'h90, 8'h07};
  logic [2:0]  mode_tab [5] = '{3'h1, 3'h2, 3'h3, 3'h0, 3'h0};
  int          n_fail = 0, checks = 0, cycles = 0;

  always #25 clk_in = ~clk_in;

  serial_port_mode_control i_serial_port_mode_control (
    .clk_in(clk_in), .reset_in(reset_in), .switches_in(switches_in),
    .current_loop_in(loop_sel), .hw_handshake_in(hw_hs), .rx_can_accept_in(can_acc),
    .tcp_connected_in(tcp), .tx_pending_in(pend), .tx_busy_in(busy), .tx_data_in(txd),
    .cts_in(cts), .rx_data_in(rxd), .half_duplex_select_n_in(hd_n),
    .baud_divisor_in(div), .tx_line_out(tx_line), .tx_allowed_out(tx_ok),
    .rts_out(rts), .dtr_out(dtr), .driver_enable_out(drv_en),
    .receiver_enable_out(rcv_en), .rx_data_out(rx_out), .baud_reject_out(reject),
    .mode_out(mode));

  serial_peer_model i_serial_peer_model (
    .clk_in(clk_in), .ready_in(p_ready), .send_in(p_send), .bit_in(p_bit),
    .rts_in(rts), .cts_out(cts), .rxd_out(rxd));

  // ------------------------------------------------------------
  // Access and comparison tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic settle();
    repeat (3) @(posedge clk_in);
    #1;
  endtask : settle

  task automatic restart(input logic [7:0] sw);
    @(posedge clk_in);
    reset_in    <= 1'b1;
    switches_in <= sw;
    repeat (5) @(posedge clk_in);
    #1;
    chk(tx_line, 1'b1);
    chk(drv_en, 1'b0);
    @(posedge clk_in);
    reset_in <= 1'b0;
    settle();
  endtask : restart

  task automatic summarize();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      summarize();
    end
  end

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    restart(8'h00);
    chk(mode, 3'h0);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_in);
      hw_hs   <= 1'b1;
      can_acc <= i[0];
      tcp     <= i[1];
      p_ready <= i[0] ^ i[1];
      settle();
      chk(rts, i[0]);
      chk(dtr, i[1]);
      chk(tx_ok, i[0] ^ i[1]);
      chk(tx_line, !(i[0] ^ i[1]));
    end
    @(posedge clk_in);
    hw_hs <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      restart(sw_tab[i]);
      chk(mode, mode_tab[i]);
      if (i == 0) begin
        chk(drv_en, 1'b1);
        chk(rcv_en, 1'b1);
        @(posedge clk_in);
        hw_hs <= 1'b1;
        settle();
        chk(rts, 1'b1);
        chk(tx_ok, 1'b0);
        @(posedge clk_in);
        hw_hs <= 1'b0;
      end
    end
    for (int i = 1; i < 3; i++) begin
      restart(sw_tab[i]);
      @(posedge clk_in);
      switches_in <= 8'h00;
      pend        <= 1'b1;
      p_send      <= 1'b1;
      p_bit       <= 1'b0;
      settle();
      chk(mode, mode_tab[i]);
      chk(drv_en, 1'b1);
      chk(rcv_en, i == 1);
      chk(rx_out, i == 2);
      @(posedge clk_in);
      pend <= 1'b0;
      busy <= 1'b1;
      settle();
      chk(drv_en, 1'b1);
      @(posedge clk_in);
      busy <= 1'b0;
      settle();
      chk(drv_en, 1'b0);
      chk(rcv_en, 1'b1);
      chk(rx_out, 1'b0);
    end
    restart(8'h00);
    @(posedge clk_in);
    loop_sel <= 1'b1;
    div      <= 16'h0411;
    busy     <= 1'b1;
    hd_n     <= 1'b0;
    settle();
    chk(reject, 1'b1);
    chk(rx_out, 1'b1);
    @(posedge clk_in);
    div  <= 16'h0412;
    hd_n <= 1'b1;
    settle();
    chk(reject, 1'b0);
    chk(rx_out, 1'b0);
    summarize();
  end
endmodule : tb_top
